// ==== common/ecl_pkg.sv ====
// shared constants and types for the port 0 statistics tallies
package ecl_pkg;

  localparam int unsigned TALLY_W   = 16;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned NUM_TALLY = 3;
  localparam int unsigned ADDR_W    = 7;

  // byte offsets of the six registers
  localparam logic [7:0] PORT0_ERRORED_FRAME_COUNT_HIGH = 8'h92;
  localparam logic [7:0] PORT0_ERRORED_FRAME_COUNT_LOW  = 8'h93;
  localparam logic [7:0] PORT0_LINE_TALLY_HIGH          = 8'h94;
  localparam logic [7:0] PORT0_LINE_TALLY_LOW           = 8'h95;
  localparam logic [7:0] PORT0_ERRORED_LINE_COUNT_HIGH  = 8'h96;
  localparam logic [7:0] PORT0_ERRORED_LINE_COUNT_LOW   = 8'h97;

  // index 0 errored frames, 1 lines, 2 errored lines
  localparam logic [2:0][7:0] TALLY_HI_OFS = {PORT0_ERRORED_LINE_COUNT_HIGH,
                                              PORT0_LINE_TALLY_HIGH,
                                              PORT0_ERRORED_FRAME_COUNT_HIGH};
  localparam logic [2:0][7:0] TALLY_LO_OFS = {PORT0_ERRORED_LINE_COUNT_LOW,
                                              PORT0_LINE_TALLY_LOW,
                                              PORT0_ERRORED_FRAME_COUNT_LOW};

  localparam logic [7:0] REG_RST      = 8'h00;
  localparam logic [7:0] RD_UNMAPPED  = 8'h00;
  localparam logic [7:0] PTR_RST      = 8'h00;
  localparam logic [3:0] BCNT_RST     = 4'h0;
  localparam logic [3:0] BITS_DONE    = 4'h8;
  localparam logic [3:0] LAST_BIT     = 4'h7;
  localparam logic       BUS_IDLE     = 1'b1;
  // bus address of the device, value arbitrary
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h3D;

  typedef enum logic [6:0] {
    ECL_IDLE     = 7'h01,
    ECL_ADDR     = 7'h02,
    ECL_ADDR_ACK = 7'h04,
    ECL_WR_BYTE  = 7'h08,
    ECL_WR_ACK   = 7'h10,
    ECL_RD_BYTE  = 7'h20,
    ECL_RD_ACK   = 7'h40
  } ecl_i2c_st_t;

endpackage : ecl_pkg

// ==== hw/ecl_tally.sv ====
// one saturating event tally with clear-on-read and low byte snapshot
`timescale 1ns/10ps
module ecl_tally #(
  parameter int unsigned WIDTH = ecl_pkg::TALLY_W
) (
  input  wire logic                      ref_clk_i, // system clock
  input  wire logic                      sys_rst_i, // sync reset, high
  input  wire logic                      evt_i,     // one count event
  input  wire logic                      clr_i,     // high byte being read
  output logic      [WIDTH-1:0]          count_o,   // live count
  output logic      [ecl_pkg::BYTE_W-1:0] snap_o    // captured low byte
);

  typedef struct packed {
    logic [WIDTH-1:0]           cnt;
    logic [ecl_pkg::BYTE_W-1:0] snap;
  } ecl_tally_t;

  localparam logic [WIDTH-1:0] CNT_MAX = {WIDTH{1'b1}};
  localparam logic [WIDTH-1:0] CNT_ONE = WIDTH'(1);
  localparam ecl_tally_t TALLY_RST = '{cnt: '0, snap: ecl_pkg::REG_RST};

  ecl_tally_t s_r;
  ecl_tally_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (clr_i) begin
      s_nxt.snap = s_r.cnt[ecl_pkg::BYTE_W-1:0];
      s_nxt.cnt  = evt_i ? CNT_ONE : '0;
    end else if (evt_i && (s_r.cnt != CNT_MAX)) begin
      s_nxt.cnt = s_r.cnt + CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_r <= TALLY_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count_o = s_r.cnt;
  assign snap_o  = s_r.snap;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_clr_to_zero: assert property (
    clr_i |=> s_r.cnt == ($past(evt_i) ? CNT_ONE : '0))
    else $error("tally not cleared by high byte read");
  a_snap_low: assert property (
    clr_i |=> s_r.snap == $past(s_r.cnt[ecl_pkg::BYTE_W-1:0]))
    else $error("snapshot does not hold old low byte");
  a_snap_hold: assert property (
    !clr_i |=> $stable(s_r.snap))
    else $error("snapshot changed without a high byte read");
  a_inc_one: assert property (
    (!clr_i && evt_i && s_r.cnt != CNT_MAX) |=> s_r.cnt == $past(s_r.cnt) + CNT_ONE)
    else $error("tally did not step by one");
  a_sat_hold: assert property (
    (!clr_i && s_r.cnt == CNT_MAX) |=> s_r.cnt == CNT_MAX)
    else $error("tally wrapped past maximum");
  a_idle_hold: assert property (
    (!clr_i && !evt_i) |=> $stable(s_r.cnt))
    else $error("tally moved without an event");

endmodule : ecl_tally

// ==== hw/ecl_i2c_cond.sv ====
// scl edge and start/stop condition detector for the control port
`timescale 1ns/10ps
module ecl_i2c_cond (
  input  wire logic ref_clk_i,  // system clock
  input  wire logic sys_rst_i,  // sync reset, high
  input  wire logic scl_i,      // control port clock level
  input  wire logic sda_i,      // control port data level
  output logic      scl_rise_o, // scl went high this cycle
  output logic      scl_fall_o, // scl went low this cycle
  output logic      start_o,    // start or repeated start
  output logic      stop_o      // stop condition
);

  typedef struct packed {
    logic scl_q;
    logic sda_q;
  } ecl_cond_t;

  localparam ecl_cond_t COND_RST = '{scl_q: ecl_pkg::BUS_IDLE, sda_q: ecl_pkg::BUS_IDLE};

  ecl_cond_t s_r;
  ecl_cond_t s_nxt;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.scl_q = scl_i;
    s_nxt.sda_q = sda_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_r <= COND_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // sda moving while scl stays high marks a bus condition
  assign scl_rise_o = scl_i & ~s_r.scl_q;
  assign scl_fall_o = ~scl_i & s_r.scl_q;
  assign start_o    = scl_i & s_r.scl_q & s_r.sda_q & ~sda_i;
  assign stop_o     = scl_i & s_r.scl_q & ~s_r.sda_q & sda_i;

endmodule : ecl_i2c_cond

// ==== hw/ecl_port0_tallies.sv ====
// port 0 frame/line statistics tallies behind the control port slave
`timescale 1ns/10ps
module ecl_port0_tallies #(
  parameter logic [ecl_pkg::ADDR_W-1:0] DEV_ADDR = ecl_pkg::DEV_ADDR_DFLT // bus address
) (
  input  wire logic ref_clk_i,       // system clock, 100 MHz
  input  wire logic sys_rst_i,       // sync reset, high
  input  wire logic scl_i,           // control port clock level
  input  wire logic sda_i,           // control port data level
  output logic      sda_o,           // data drive value, always low
  output logic      sda_oe_o,        // high while pulling data low
  input  wire logic frame_err_evt_i, // frame with errors sent
  input  wire logic line_evt_i,      // line sent
  input  wire logic line_err_evt_i   // line with errors sent
);

  localparam int unsigned NT = ecl_pkg::NUM_TALLY;
  localparam int unsigned BW = ecl_pkg::BYTE_W;
  localparam int unsigned TW = ecl_pkg::TALLY_W;

  typedef struct packed {
    ecl_pkg::ecl_i2c_st_t st;
    logic [7:0]           shf;
    logic [3:0]           bcnt;
    logic [7:0]           ptr;
    logic                 first;
    logic                 rw;
    logic                 nack;
    logic                 sda_oe;
    logic                 sda;
  } ecl_port_t;

  localparam ecl_port_t PORT_RST = '{
    st:     ecl_pkg::ECL_IDLE,
    shf:    ecl_pkg::REG_RST,
    bcnt:   ecl_pkg::BCNT_RST,
    ptr:    ecl_pkg::PTR_RST,
    first:  1'b0,
    rw:     1'b0,
    nack:   1'b0,
    sda_oe: 1'b0,
    sda:    1'b0
  };

  ecl_port_t s_r;
  ecl_port_t s_nxt;

  logic                  scl_rise;
  logic                  scl_fall;
  logic                  bus_start;
  logic                  bus_stop;
  logic                  rd_load;
  logic [7:0]            rd_byte;
  logic [NT-1:0]         evt_w;
  logic [NT-1:0]         hi_hit;
  logic [NT-1:0]         lo_hit;
  logic [NT-1:0]         tally_clr;
  logic [NT-1:0][TW-1:0] cnt_w;
  logic [NT-1:0][BW-1:0] snap_w;

  ecl_i2c_cond u_cond (
    .ref_clk_i  (ref_clk_i),
    .sys_rst_i  (sys_rst_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .scl_rise_o (scl_rise),
    .scl_fall_o (scl_fall),
    .start_o    (bus_start),
    .stop_o     (bus_stop)
  );

  assign evt_w = {line_err_evt_i, line_evt_i, frame_err_evt_i};

  // a high byte leaves the tally in the very cycle it is loaded
  assign tally_clr = hi_hit & {NT{rd_load}};

  for (genvar g = 0; g < NT; g++) begin : g_tally
    assign hi_hit[g] = (s_r.ptr == ecl_pkg::TALLY_HI_OFS[g]);
    assign lo_hit[g] = (s_r.ptr == ecl_pkg::TALLY_LO_OFS[g]);

    ecl_tally #(
      .WIDTH (TW)
    ) u_tally (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .evt_i     (evt_w[g]),
      .clr_i     (tally_clr[g]),
      .count_o   (cnt_w[g]),
      .snap_o    (snap_w[g])
    );

    a_hi_value: assert property (
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      tally_clr[g] |=> s_r.shf == $past(cnt_w[g][TW-1 -: BW]))
      else $error("high byte read returned wrong bits");
    a_lo_value: assert property (
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      (rd_load && lo_hit[g]) |=> s_r.shf == $past(snap_w[g]))
      else $error("low byte read did not return snapshot");
    a_lo_keeps: assert property (
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      (rd_load && lo_hit[g]) |=> cnt_w[g] >= $past(cnt_w[g]))
      else $error("low byte read disturbed the tally");
  end

  always_comb begin
    s_nxt   = s_r;
    rd_load = 1'b0;
    // read data; unmapped offsets return zero
    rd_byte = ecl_pkg::RD_UNMAPPED;
    for (int k = 0; k < NT; k++) begin
      if (hi_hit[k]) begin
        rd_byte = rd_byte | cnt_w[k][TW-1 -: BW];
      end
      if (lo_hit[k]) begin
        rd_byte = rd_byte | snap_w[k];
      end
    end

    if (bus_stop) begin
      s_nxt.st     = ecl_pkg::ECL_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else if (bus_start) begin
      s_nxt.st     = ecl_pkg::ECL_ADDR;
      s_nxt.bcnt   = ecl_pkg::BCNT_RST;
      s_nxt.sda_oe = 1'b0;
    end else begin
      case (s_r.st)
        ecl_pkg::ECL_IDLE: begin
          s_nxt.sda_oe = 1'b0;
        end
        ecl_pkg::ECL_ADDR: begin
          if (scl_rise) begin
            s_nxt.shf  = {s_r.shf[6:0], sda_i};
            s_nxt.bcnt = s_r.bcnt + 4'h1;
          end else if (scl_fall && s_r.bcnt == ecl_pkg::BITS_DONE) begin
            if (s_r.shf[7:1] == DEV_ADDR) begin
              s_nxt.st     = ecl_pkg::ECL_ADDR_ACK;
              s_nxt.sda_oe = 1'b1;
              s_nxt.rw     = s_r.shf[0];
            end else begin
              s_nxt.st = ecl_pkg::ECL_IDLE;
            end
          end
        end
        ecl_pkg::ECL_ADDR_ACK: begin
          if (scl_fall) begin
            if (s_r.rw) begin
              rd_load = 1'b1;
            end else begin
              s_nxt.st     = ecl_pkg::ECL_WR_BYTE;
              s_nxt.sda_oe = 1'b0;
              s_nxt.bcnt   = ecl_pkg::BCNT_RST;
              s_nxt.first  = 1'b1;
            end
          end
        end
        ecl_pkg::ECL_WR_BYTE: begin
          if (scl_rise) begin
            s_nxt.shf  = {s_r.shf[6:0], sda_i};
            s_nxt.bcnt = s_r.bcnt + 4'h1;
          end else if (scl_fall && s_r.bcnt == ecl_pkg::BITS_DONE) begin
            s_nxt.st     = ecl_pkg::ECL_WR_ACK;
            s_nxt.sda_oe = 1'b1;
            s_nxt.first  = 1'b0;
            // first byte sets the offset; data to read-only offsets is dropped
            if (s_r.first) begin
              s_nxt.ptr = s_r.shf;
            end else begin
              s_nxt.ptr = s_r.ptr + 8'h01;
            end
          end
        end
        ecl_pkg::ECL_WR_ACK: begin
          if (scl_fall) begin
            s_nxt.st     = ecl_pkg::ECL_WR_BYTE;
            s_nxt.sda_oe = 1'b0;
            s_nxt.bcnt   = ecl_pkg::BCNT_RST;
          end
        end
        ecl_pkg::ECL_RD_BYTE: begin
          if (scl_fall) begin
            if (s_r.bcnt == ecl_pkg::LAST_BIT) begin
              s_nxt.st     = ecl_pkg::ECL_RD_ACK;
              s_nxt.sda_oe = 1'b0;
            end else begin
              s_nxt.shf    = {s_r.shf[6:0], 1'b0};
              s_nxt.sda_oe = ~s_r.shf[6];
              s_nxt.bcnt   = s_r.bcnt + 4'h1;
            end
          end
        end
        ecl_pkg::ECL_RD_ACK: begin
          if (scl_rise) begin
            s_nxt.nack = sda_i;
          end else if (scl_fall) begin
            if (s_r.nack) begin
              s_nxt.st = ecl_pkg::ECL_IDLE;
            end else begin
              rd_load = 1'b1;
            end
          end
        end
        default: begin
          s_nxt.st     = ecl_pkg::ECL_IDLE;
          s_nxt.sda_oe = 1'b0;
        end
      endcase
    end

    // a byte is fetched at the scl fall that starts its first bit
    if (rd_load) begin
      s_nxt.st     = ecl_pkg::ECL_RD_BYTE;
      s_nxt.shf    = rd_byte;
      s_nxt.sda_oe = ~rd_byte[7];
      s_nxt.bcnt   = ecl_pkg::BCNT_RST;
      s_nxt.ptr    = s_r.ptr + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_r <= PORT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sda_o    = s_r.sda;
  assign sda_oe_o = s_r.sda_oe;

  sequence s_addr_end;
    (s_r.st == ecl_pkg::ECL_ADDR) && scl_fall && !bus_stop && !bus_start &&
    (s_r.bcnt == ecl_pkg::BITS_DONE) && (s_r.shf[7:1] == DEV_ADDR);
  endsequence

  sequence s_ack_drive;
    (s_r.st == ecl_pkg::ECL_ADDR_ACK) && s_r.sda_oe;
  endsequence

  a_addr_ack: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    s_addr_end |=> s_ack_drive)
    else $error("own address not acknowledged");
  a_rd_bit: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (s_r.st == ecl_pkg::ECL_RD_BYTE) |-> (s_r.sda_oe == !s_r.shf[7]))
    else $error("read data bit not on the bus");
  a_ptr_step: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    rd_load |=> s_r.ptr == $past(s_r.ptr) + 8'h01)
    else $error("offset did not advance after a read byte");

  sequence s_rd_last_fall;
    (s_r.st == ecl_pkg::ECL_RD_BYTE) && scl_fall && !bus_stop && !bus_start &&
    (s_r.bcnt == ecl_pkg::LAST_BIT);
  endsequence

  sequence s_ack_window;
    (s_r.st == ecl_pkg::ECL_RD_ACK) && !s_r.sda_oe;
  endsequence

  sequence s_wr_first_end;
    (s_r.st == ecl_pkg::ECL_WR_BYTE) && s_r.first && scl_fall && !bus_stop && !bus_start &&
    (s_r.bcnt == ecl_pkg::BITS_DONE);
  endsequence

  a_rd_release: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    s_rd_last_fall |=> s_ack_window)
    else $error("data line not released for master ack");
  a_ptr_load: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    s_wr_first_end |=> s_r.ptr == $past(s_r.shf))
    else $error("offset byte not loaded into pointer");
  a_rd_fetch: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    ((s_r.st == ecl_pkg::ECL_ADDR_ACK) && s_r.rw && scl_fall && !bus_stop) |-> rd_load)
    else $error("read byte not fetched after address ack");
  a_nack_ends: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    ((s_r.st == ecl_pkg::ECL_RD_ACK) && s_r.nack && scl_fall && !bus_stop)
      |=> (s_r.st == ecl_pkg::ECL_IDLE) && !s_r.sda_oe)
    else $error("read went on after master nack");
  a_stop_idle: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    bus_stop |=> (s_r.st == ecl_pkg::ECL_IDLE) && !s_r.sda_oe)
    else $error("stop did not return to idle");
  a_start_addr: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    bus_start |=> (s_r.st == ecl_pkg::ECL_ADDR) && (s_r.bcnt == ecl_pkg::BCNT_RST))
    else $error("start did not open an address phase");
  a_foreign_idle: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    ((s_r.st == ecl_pkg::ECL_ADDR) && scl_fall && !bus_stop &&
     (s_r.bcnt == ecl_pkg::BITS_DONE) && (s_r.shf[7:1] != DEV_ADDR))
      |=> (s_r.st == ecl_pkg::ECL_IDLE) && !s_r.sda_oe)
    else $error("foreign address was answered");
  a_idle_quiet: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (s_r.st == ecl_pkg::ECL_IDLE) |-> !s_r.sda_oe)
    else $error("data line driven while idle");
  a_oe_on_fall: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $changed(s_r.sda_oe) |-> $past(scl_fall) || $past(bus_start) || $past(bus_stop))
    else $error("data line drive changed while clock high");
  a_wr_no_clear: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (s_r.st == ecl_pkg::ECL_WR_BYTE || s_r.st == ecl_pkg::ECL_WR_ACK) |-> (tally_clr == '0))
    else $error("write phase cleared a tally");

endmodule : ecl_port0_tallies

// ==== tb/ecl_port0_tallies_tb.sv ====
// self-checking bench for the port 0 statistics tallies
`timescale 1ns/10ps
module ecl_port0_tallies_tb;
  logic        ref_clk_i  = 1'b0;
  logic        sys_rst_i  = 1'b1;
  logic        scl_m      = 1'b1;
  logic        sda_m      = 1'b1;
  logic [2:0]  evt        = 3'h0;
  logic        sda_dev;
  logic        sda_oe;
  wire         sda_w      = sda_m & (sda_oe ? sda_dev : 1'b1);
  int          mismatches = 0;
  int          tests_run  = 0;
  logic [15:0] exp_cnt [3];
  logic [7:0]  snap [3];
  logic [7:0]  rd [6];
  logic        ack;
  logic [15:0] first_v [3];
  time         t0;
  int          held;

  always #5 ref_clk_i = ~ref_clk_i;

  ecl_port0_tallies #(.DEV_ADDR(ecl_pkg::DEV_ADDR_DFLT)) dut_u (
    .ref_clk_i       (ref_clk_i),
    .sys_rst_i       (sys_rst_i),
    .scl_i           (scl_m),
    .sda_i           (sda_w),
    .sda_o           (sda_dev),
    .sda_oe_o        (sda_oe),
    .frame_err_evt_i (evt[0]),
    .line_evt_i      (evt[1]),
    .line_err_evt_i  (evt[2])
  );

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : tick

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask : chk

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction : sat_inc

  // one bus bit: data set while clock low, wire sampled mid-high
  task automatic bit_cyc(input logic b, output logic s);
    sda_m <= b;
    tick(2);
    scl_m <= 1'b1;
    tick(2);
    #1 s = sda_w;
    tick(2);
    scl_m <= 1'b0;
    tick(2);
  endtask : bit_cyc

  task automatic start_c;
    sda_m <= 1'b1;
    tick(2);
    scl_m <= 1'b1;
    tick(2);
    sda_m <= 1'b0;
    tick(2);
    scl_m <= 1'b0;
    tick(2);
  endtask : start_c

  task automatic stop_c;
    sda_m <= 1'b0;
    tick(2);
    scl_m <= 1'b1;
    tick(2);
    sda_m <= 1'b1;
    tick(2);
  endtask : stop_c

  task automatic wr_byte(input logic [7:0] v, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(v[i], s);
    end
    bit_cyc(1'b1, a);
  endtask : wr_byte

  // last byte answered with nack
  task automatic rd_byte(input logic last, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b1, s);
      v[i] = s;
    end
    bit_cyc(last, s);
  endtask : rd_byte

  task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] d);
    start_c();
    wr_byte({ecl_pkg::DEV_ADDR_DFLT, 1'b0}, ack);
    chk("addr ack", 16'h0000, ack);
    wr_byte(ofs, ack);
    chk("offset ack", 16'h0000, ack);
    wr_byte(d, ack);
    chk("data ack", 16'h0000, ack);
    stop_c();
  endtask : wr_reg

  task automatic read_regs(input logic [7:0] ofs, input int n);
    start_c();
    wr_byte({ecl_pkg::DEV_ADDR_DFLT, 1'b0}, ack);
    chk("addr ack", 16'h0000, ack);
    wr_byte(ofs, ack);
    chk("offset ack", 16'h0000, ack);
    start_c();
    wr_byte({ecl_pkg::DEV_ADDR_DFLT, 1'b1}, ack);
    chk("read addr ack", 16'h0000, ack);
    for (int i = 0; i < n; i++) begin
      rd_byte(i == n - 1, rd[i]);
    end
    stop_c();
  endtask : read_regs

  // events for n cycles, random per cycle unless all is set
  task automatic run_evts(input int n, input logic [2:0] mask, input logic all);
    logic [2:0] e;
    for (int c = 0; c < n; c++) begin
      e = all ? mask : (3'($urandom) & mask);
      evt <= e;
      for (int k = 0; k < 3; k++) begin
        if (e[k]) begin
          exp_cnt[k] = sat_inc(exp_cnt[k]);
        end
      end
      tick(1);
    end
    evt <= 3'h0;
    tick(1);
  endtask : run_evts

  // burst from first high byte: hi then coherent lo for each tally
  task automatic check_all;
    read_regs(ecl_pkg::PORT0_ERRORED_FRAME_COUNT_HIGH, 6);
    for (int k = 0; k < 3; k++) begin
      chk("tally hi", exp_cnt[k][15:8], rd[2*k]);
      chk("tally lo", exp_cnt[k][7:0], rd[2*k+1]);
      snap[k] = exp_cnt[k][7:0];
      exp_cnt[k] = 16'h0000;
    end
  endtask : check_all

  initial begin
    repeat (95000) @(posedge ref_clk_i);
    mismatches++;
    end_sim();
  end

  initial begin
    void'($urandom(32'hC636B0E7));
    for (int k = 0; k < 3; k++) begin
      exp_cnt[k] = 16'h0000;
    end
    tick(2);
    sys_rst_i <= 1'b0;
    tick(1);
    check_all();
    for (int it = 0; it < 6; it++) begin
      run_evts(200 + $urandom_range(0, 600), 3'h7, 1'b0);
      check_all();
    end
    // events held across the clearing reads: none lost, none counted twice
    t0 = $time;
    evt <= 3'h7;
    read_regs(ecl_pkg::PORT0_ERRORED_FRAME_COUNT_HIGH, 6);
    evt <= 3'h0;
    // one event per 10 ns clock edge while held
    held = int'(($time - t0) / 10);
    for (int k = 0; k < 3; k++) begin
      first_v[k] = {rd[2*k], rd[2*k+1]};
    end
    tick(1);
    read_regs(ecl_pkg::PORT0_ERRORED_FRAME_COUNT_HIGH, 6);
    for (int k = 0; k < 3; k++) begin
      chk("split sum", 16'(held), first_v[k] + {rd[2*k], rd[2*k+1]});
    end
    run_evts(300, 3'h7, 1'b1);
    check_all();
    run_evts(50, 3'h7, 1'b1);
    read_regs(ecl_pkg::PORT0_ERRORED_FRAME_COUNT_LOW, 1);
    chk("lo without hi", snap[0], rd[0]);
    read_regs(ecl_pkg::PORT0_ERRORED_LINE_COUNT_LOW, 1);
    chk("lo without hi", snap[2], rd[0]);
    check_all();
    run_evts(20, 3'h1, 1'b1);
    wr_reg(ecl_pkg::PORT0_ERRORED_FRAME_COUNT_HIGH, 8'hA5);
    read_regs(8'h98, 1);
    chk("unmapped", 16'h0000, rd[0]);
    check_all();
    start_c();
    wr_byte({ecl_pkg::DEV_ADDR_DFLT ^ 7'h01, 1'b0}, ack);
    chk("foreign addr nack", 16'h0001, ack);
    stop_c();
    run_evts(10, 3'h7, 1'b1);
    sys_rst_i <= 1'b1;
    tick(2);
    sys_rst_i <= 1'b0;
    tick(1);
    for (int k = 0; k < 3; k++) begin
      exp_cnt[k] = 16'h0000;
    end
    check_all();
    run_evts(65540, 3'h2, 1'b1);
    check_all();
    end_sim();
  end
endmodule : ecl_port0_tallies_tb
